// file: pkg/tcp_pkg.sv
package tcp_pkg;

    // ==========================================================================
    // Register byte addresses
    // ==========================================================================
    localparam logic [15:0] ADDR_DUTY_CH0     = 16'h1fb0;
    localparam logic [15:0] ADDR_DUTY_CH1     = 16'h1fb2;
    localparam logic [15:0] ADDR_DUTY_CH2     = 16'h1fb4;
    localparam logic [15:0] ADDR_PRESCALE     = 16'h1fb6;
    localparam logic [15:0] ADDR_FUNC_SEL     = 16'h1fd9;
    localparam logic [15:0] ADDR_DIRECTION    = 16'h1fdb;
    localparam logic [15:0] ADDR_OUT_DATA     = 16'h1fdd;
    localparam logic [15:0] ADDR_PIN_STATE    = 16'h1fdf;

    // ==========================================================================
    // Fields and reset values
    // ==========================================================================
    localparam int          PRESCALE_HALF_BIT    = 0;
    localparam int          PRESCALE_QUARTER_BIT = 1;
    localparam logic [7:0]  RST_PRESCALE      = 8'h00;
    localparam logic [7:0]  RST_DUTY          = 8'h00;
    localparam logic [7:0]  RST_FUNC_SEL      = 8'h00;
    localparam logic [7:0]  RST_DIRECTION     = 8'hff;
    localparam logic [7:0]  RST_OUT_DATA      = 8'hff;
    localparam logic [7:0]  READ_UNMAPPED     = 8'h00;
    localparam logic [7:0]  COUNT_MAX         = 8'hff;
    localparam logic [7:0]  COUNT_ZERO        = 8'h00;
    localparam logic [1:0]  DIV_ONE           = 2'h0;
    localparam logic [1:0]  DIV_TWO           = 2'h1;
    localparam logic [1:0]  DIV_FOUR          = 2'h3;
    localparam int          NUM_CH            = 3;

    // ==========================================================================
    // Types
    // ==========================================================================
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } tcp_bus_req_t;

    typedef enum logic [1:0] {
        TCP_RATE_FULL    = 2'b00,
        TCP_RATE_HALF    = 2'b01,
        TCP_RATE_QUARTER = 2'b10
    } tcp_rate_t;

    typedef struct packed {
        logic [7:0]  duty0;
        logic [7:0]  duty1;
        logic [7:0]  duty2;
        logic [7:0]  buf0;
        logic [7:0]  buf1;
        logic [7:0]  buf2;
        logic [7:0]  prescale;
        logic [7:0]  func_sel;
        logic [7:0]  direction;
        logic [7:0]  out_data;
        logic [7:0]  counter;
        logic [1:0]  divcnt;
        logic [2:0]  pulse;
        logic [7:0]  pin_s1;
        logic [7:0]  pin_s2;
        logic [7:0]  rdata;
        logic [7:0]  port_out;
        logic [7:0]  port_oe;
    } tcp_state_t;

endpackage : tcp_pkg

// file: hdl/tcp_pwm_port.sv
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
// Overview of operation
// - Three modulated channels drive port bits 0, 1 and 2, push-pull where the direction bit is clear, else open drain.
// - Two-rate use: prescale bit 0 set halves the counter rate for all channels.
// - Three-rate use: prescale bits 0 and 1 pick divide by one, two or four.
// - Each channel has its own duty register setting the high time per period.
// - Duty value zero keeps that channel's output low all the time.
// - Duty value all ones gives high for 255 of 256 counts.
// - Direction bit set means open-drain output or high-impedance input alike.
// - Function-select bits 0, 1 and 2 each pick plain port pin or special function.
// - Pin-state register reads the pin level through a two-stage synchronizer, whatever the mode.
// - Output data register holds the values driven on plain output pins.
// - Duty registers are copied to compare buffers when the counter wraps to zero.
// - Output goes high at wrap, low at compare match; zero duty stays low.
// - Counter advances each state time, or every second one when halved.
// - Prescale bit 1 set selects divide by four and bit 0 is ignored.
module tcp_pwm_port
    import tcp_pkg::*;
#(
    parameter bit THREE_RATE = 1'b1
) (
    // Clock and reset
    input  wire logic         i_clk_sys,
    input  wire logic         i_rst_n,
    // Register port
    input  wire tcp_bus_req_t i_bus,
    output logic [7:0]        o_rdata,
    // Port pins
    input  wire logic [7:0]   i_port_pin,
    output logic [7:0]        o_port_out,
    output logic [7:0]        o_port_oe
);

    // ==========================================================================
    // State
    // ==========================================================================
    tcp_state_t st_reg;
    tcp_state_t st_next;
    tcp_rate_t  rate;
    logic [1:0] div_limit;
    logic       tick;
    logic       wrap;
    logic [7:0] duty_w   [NUM_CH];
    logic [7:0] buf_w    [NUM_CH];
    logic [NUM_CH-1:0] pulse_next;

    assign duty_w[0] = st_reg.duty0;
    assign duty_w[1] = st_reg.duty1;
    assign duty_w[2] = st_reg.duty2;
    assign buf_w[0]  = st_reg.buf0;
    assign buf_w[1]  = st_reg.buf1;
    assign buf_w[2]  = st_reg.buf2;

    // ==========================================================================
    // Prescaler
    // ==========================================================================
    always_comb begin
        if (THREE_RATE && st_reg.prescale[PRESCALE_QUARTER_BIT]) begin
            rate = TCP_RATE_QUARTER;
        end else if (st_reg.prescale[PRESCALE_HALF_BIT]) begin
            rate = TCP_RATE_HALF;
        end else begin
            rate = TCP_RATE_FULL;
        end
        case (rate)
            TCP_RATE_FULL:    div_limit = DIV_ONE;
            TCP_RATE_HALF:    div_limit = DIV_TWO;
            TCP_RATE_QUARTER: div_limit = DIV_FOUR;
            default:          div_limit = DIV_ONE;
        endcase
    end

    // Changing the rate mid-period only shortens or stretches the current tick, so a
    // divider count above the new limit is caught by the >= compare.
    assign tick = (st_reg.divcnt >= div_limit);
    assign wrap = tick && (st_reg.counter == COUNT_MAX);

    // ==========================================================================
    // Channels
    // ==========================================================================
    // Each match compare sees only its buffered value and the wrap start reads the duty being buffered, so software may rewrite
    // a duty register at any moment without a glitch in the running period.
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
        always_comb begin
            if (wrap) begin
                pulse_next[ch] = (duty_w[ch] != COUNT_ZERO);
            end else if (tick && ((st_reg.counter + 8'h01) == buf_w[ch])) begin
                pulse_next[ch] = 1'b0;
            end else begin
                pulse_next[ch] = st_reg.pulse[ch];
            end
        end
    end

    // ==========================================================================
    // Next state
    // ==========================================================================
    always_comb begin
        st_next        = st_reg;
        st_next.pin_s1 = i_port_pin;
        st_next.pin_s2 = st_reg.pin_s1;
        st_next.rdata  = READ_UNMAPPED;
        st_next.divcnt = tick ? 2'h0 : st_reg.divcnt + 2'h1;
        st_next.pulse  = pulse_next;
        if (tick) begin
            st_next.counter = st_reg.counter + 8'h01;
        end
        if (wrap) begin
            st_next.buf0 = st_reg.duty0;
            st_next.buf1 = st_reg.duty1;
            st_next.buf2 = st_reg.duty2;
        end

        if (i_bus.wr) begin
            case (i_bus.addr)
                ADDR_DUTY_CH0:  st_next.duty0     = i_bus.wdata;
                ADDR_DUTY_CH1:  st_next.duty1     = i_bus.wdata;
                ADDR_DUTY_CH2:  st_next.duty2     = i_bus.wdata;
                ADDR_PRESCALE:  st_next.prescale  = i_bus.wdata;
                ADDR_FUNC_SEL:  st_next.func_sel  = i_bus.wdata;
                ADDR_DIRECTION: st_next.direction = i_bus.wdata;
                ADDR_OUT_DATA:  st_next.out_data  = i_bus.wdata;
                default: begin
                end
            endcase
        end

        if (i_bus.rd) begin
            case (i_bus.addr)
                ADDR_DUTY_CH0:  st_next.rdata = st_reg.duty0;
                ADDR_DUTY_CH1:  st_next.rdata = st_reg.duty1;
                ADDR_DUTY_CH2:  st_next.rdata = st_reg.duty2;
                ADDR_PRESCALE:  st_next.rdata = st_reg.prescale;
                ADDR_FUNC_SEL:  st_next.rdata = st_reg.func_sel;
                ADDR_DIRECTION: st_next.rdata = st_reg.direction;
                ADDR_OUT_DATA:  st_next.rdata = st_reg.out_data;
                ADDR_PIN_STATE: st_next.rdata = st_reg.pin_s2;
                default:        st_next.rdata = READ_UNMAPPED;
            endcase
        end

        // Pin drivers: direction 1 is open drain, which only pulls low; the
        // same setting with data 1 leaves the pin free as an input.
        for (int b = 0; b < 8; b++) begin
            logic lvl;
            lvl = st_reg.out_data[b];
            if (b < NUM_CH && st_reg.func_sel[b]) begin
                lvl = st_reg.pulse[b];
            end
            if (st_reg.direction[b]) begin
                st_next.port_out[b] = 1'b0;
                st_next.port_oe[b]  = ~lvl;
            end else begin
                st_next.port_out[b] = lvl;
                st_next.port_oe[b]  = 1'b1;
            end
        end
    end

    // ==========================================================================
    // Registers
    // ==========================================================================
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg           <= '0;
            st_reg.duty0     <= RST_DUTY;
            st_reg.duty1     <= RST_DUTY;
            st_reg.duty2     <= RST_DUTY;
            st_reg.prescale  <= RST_PRESCALE;
            st_reg.func_sel  <= RST_FUNC_SEL;
            st_reg.direction <= RST_DIRECTION;
            st_reg.out_data  <= RST_OUT_DATA;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_rdata    = st_reg.rdata;
    assign o_port_out = st_reg.port_out;
    assign o_port_oe  = st_reg.port_oe;

endmodule : tcp_pwm_port

// file: dv/tcp_pwm_port_sva.sv
`timescale 1ns/1ps
// ==========
// Pin-level checker.
module tcp_pwm_port_sva
    import tcp_pkg::*;
#(
    parameter bit THREE_RATE = 1'b1
) (
    // Clock, reset, bus and pins
    input wire logic         i_clk_sys,
    input wire logic         i_rst_n,
    input wire tcp_bus_req_t i_bus,
    input wire logic [7:0]   o_rdata,
    input wire logic [7:0]   i_port_pin,
    input wire logic [7:0]   o_port_out,
    input wire logic [7:0]   o_port_oe
);
    localparam logic [7:0] RV [8] = '{RST_DUTY, RST_DUTY, RST_DUTY, RST_PRESCALE,
        RST_FUNC_SEL, RST_DIRECTION, RST_OUT_DATA, 8'h00};
    logic [7:0] sh_reg [8];
    logic [9:0] hold_reg;
    logic [8:0] hi_reg;
    logic [7:0] pm;
    logic [2:0] idx;
    logic       hit, wok, cfg;
    assign idx = {i_bus.addr[6], i_bus.addr[2:1]};
    assign hit = i_bus.addr inside {ADDR_DUTY_CH0, ADDR_DUTY_CH1, ADDR_DUTY_CH2,
        ADDR_PRESCALE, ADDR_FUNC_SEL, ADDR_DIRECTION, ADDR_OUT_DATA, ADDR_PIN_STATE};
    assign wok = hit && (i_bus.addr != ADDR_PIN_STATE);
    assign pm  = ~{5'h00, sh_reg[4][2:0]};
    // Any write to a writable register restarts the hold, so a buffered old duty never meets a new shadow.
    assign cfg = sh_reg[4][0] && !sh_reg[5][0] && !sh_reg[3][0] && !(THREE_RATE && sh_reg[3][1]);
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sh_reg   <= RV;
            hold_reg <= 10'h000;
            hi_reg   <= 9'h000;
        end else begin
            if (i_bus.wr && wok) begin
                sh_reg[idx] <= i_bus.wdata;
            end
            hold_reg <= (!cfg || (i_bus.wr && wok)) ? 10'h000 : hold_reg + {9'h000, !hold_reg[9]};
            hi_reg   <= o_port_out[0] ? hi_reg + 9'h001 : 9'h000;
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    sequence ch0_rise;
        hold_reg[9] && $rose(o_port_out[0]);
    endsequence
    rd_idle_a: assert property (!$past(i_bus.rd) |-> o_rdata == 8'h00)
        else $error("read data not idle");
    unmapped_a: assert property ($past(i_bus.rd) && !$past(hit) |-> o_rdata == READ_UNMAPPED)
        else $error("unmapped read not zero");
    reg_read_a: assert property (
        $past(i_bus.rd) && $past(wok) |-> o_rdata == $past(sh_reg[idx])) else $error("bad readback");
    pin_read_a: assert property (
        $past(i_bus.rd) && $past(i_bus.addr) == ADDR_PIN_STATE |-> o_rdata == $past(i_port_pin, 3))
        else $error("pin state wrong");
    plain_drive_a: assert property (
        (o_port_out & $past(pm)) == $past(~sh_reg[5] & sh_reg[6] & pm)) else $error("plain pin wrong");
    od_low_a: assert property ((o_port_out & $past(sh_reg[5])) == 8'h00)
        else $error("open drain drives high");
    oe_drive_a: assert property (
        (o_port_oe & $past(pm)) == $past((~sh_reg[5] | ~sh_reg[6]) & pm)) else $error("pin enable wrong");
    period_a: assert property (ch0_rise |-> ##256 ($rose(o_port_out[0]) || !hold_reg[9]))
        else $error("period wrong");
    high_time_a: assert property (
        hold_reg[9] && $fell(o_port_out[0]) |-> hi_reg == {1'b0, sh_reg[0]}) else $error("high time wrong");
endmodule : tcp_pwm_port_sva
bind tcp_pwm_port tcp_pwm_port_sva #(.THREE_RATE(THREE_RATE)) u_sva (.i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n), .i_bus(i_bus), .o_rdata(o_rdata), .i_port_pin(i_port_pin),
    .o_port_out(o_port_out), .o_port_oe(o_port_oe));

// file: dv/tcp_load.sv
`timescale 1ns/1ps
// ==========
// Pin load: filter or driver input with a pull-up; a device may pull pins low.
module tcp_load (
    // Port drive and outside pull-down
    input  wire logic [7:0] i_out,
    input  wire logic [7:0] i_oe,
    input  wire logic [7:0] i_ext_low,
    // Resolved levels
    output logic [7:0]      o_pin
);
    assign o_pin = ((i_oe & i_out) | ~i_oe) & ~i_ext_low;
endmodule : tcp_load

// file: dv/tb_tcp_pwm_port.sv
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_tcp_pwm_port
    import tcp_pkg::*;
;
    logic         i_clk_sys = 1'b0;
    logic         i_rst_n, rd_seen = 1'b0;
    tcp_bus_req_t bus;
    logic [7:0]   o_rdata, pin, out, oe, ext_low, lf, ex, d [3], expq [$];
    int           mismatches, n_checks, cyc, t0, hi, per, dv;
    logic [15:0]  ad [9] = '{ADDR_DUTY_CH0, ADDR_DUTY_CH1, ADDR_DUTY_CH2, ADDR_PRESCALE,
        ADDR_FUNC_SEL, ADDR_DIRECTION, ADDR_OUT_DATA, ADDR_PIN_STATE, 16'h1fb1};
    logic [7:0]   rv [9] = '{RST_DUTY, RST_DUTY, RST_DUTY, RST_PRESCALE, RST_FUNC_SEL,
        RST_DIRECTION, RST_OUT_DATA, 8'hff, READ_UNMAPPED};
    always #5 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) cyc++;
    tcp_pwm_port dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_bus(bus),
        .o_rdata(o_rdata), .i_port_pin(pin), .o_port_out(out), .o_port_oe(oe));
    tcp_load u_load (.i_out(out), .i_oe(oe), .i_ext_low(ext_low), .o_pin(pin));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge i_clk_sys) bus <= '{a, v, 1'b1, 1'b0};
        @(posedge i_clk_sys) bus <= '0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        expq.push_back(e);
        @(posedge i_clk_sys) bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge i_clk_sys) bus <= '0;
    endtask : rd
    // Read data stand one cycle only, so they are taken at the next falling edge.
    always @(posedge i_clk_sys) rd_seen <= bus.rd;
    always @(negedge i_clk_sys) begin
        if (rd_seen) begin
            ex = expq.pop_front();
            `CHK(o_rdata, ex)
        end
    end
    task automatic meas(input int c, output int h, output int p);
        do @(negedge i_clk_sys); while (pin[c] !== 1'b0);
        do @(negedge i_clk_sys); while (pin[c] !== 1'b1);
        t0 = cyc;
        do @(negedge i_clk_sys); while (pin[c] === 1'b1);
        h = cyc - t0;
        do @(negedge i_clk_sys); while (pin[c] === 1'b0);
        p = cyc - t0;
        t0 = cyc;
    endtask : meas
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : results
    initial begin
        repeat (90000) @(posedge i_clk_sys);
        mismatches++;
        results();
    end
    initial begin
        i_rst_n = 1'b0;
        bus = '0;
        ext_low = 8'h00;
        lf = 8'h18;
        repeat (16) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        foreach (ad[i]) rd(ad[i], rv[i]);
        $display("reset test done");
        lf = lfsr(lf);
        wr(ADDR_OUT_DATA, lf | 8'h80);
        wr(ADDR_DIRECTION, lfsr(lf) | 8'h80);
        ext_low <= 8'h80;
        repeat (4) @(posedge i_clk_sys);
        rd(ADDR_PIN_STATE, lf & 8'h7f);
        $display("port test done");
        wr(ADDR_OUT_DATA, 8'hff);
        ext_low <= 8'h00;
        wr(ADDR_FUNC_SEL, 8'h07);
        for (int k = 0; k < 4; k++) begin
            lf = lfsr(lf);
            for (int c = 0; c < 3; c++) begin
                d[c] = (c == k % 3) ? 8'h00 : (c == (k + 1) % 3) ? 8'hff : lf;
                wr(ADDR_DUTY_CH0 + 16'(2 * c), d[c]);
            end
            wr(ADDR_DIRECTION, (k == 1) ? 8'hfc : 8'hf8);
            wr(ADDR_PRESCALE, 8'(k));
            dv = k[1] ? 4 : k[0] ? 2 : 1;
            repeat (600 * dv) @(posedge i_clk_sys);
            for (int c = 0; c < 3; c++) begin
                if (d[c] == 8'h00) begin
                    hi = 0;
                    repeat (300 * dv) @(negedge i_clk_sys) hi += int'(pin[c] !== 1'b0);
                    `CHK(hi, 0)
                end else begin
                    meas(c, hi, per);
                    `CHK(hi, d[c] * dv)
                    `CHK(per, 256 * dv)
                end
            end
            $display("rate test %0d done", k);
        end
        wr(ADDR_PRESCALE, 8'h00);
        wr(ADDR_DUTY_CH0, 8'h80);
        repeat (600) @(posedge i_clk_sys);
        meas(0, hi, per);
        wr(ADDR_DUTY_CH0, 8'h10);
        while (pin[0] === 1'b1) @(negedge i_clk_sys);
        `CHK(cyc - t0, 128)
        meas(0, hi, per);
        `CHK(hi, 16)
        $display("buffer test done");
        results();
    end
endmodule : tb_tcp_pwm_port
